/* File: fbp_pkg.sv */
package fbp_pkg;
  localparam int FBP_FLASH_KB    = 96;
  localparam int FBP_UNIT_BYTES  = 1024;
  localparam int FBP_UNITS_PER_R = 2;
  localparam int FBP_NUM_UNITS   = FBP_FLASH_KB * 1024 / FBP_UNIT_BYTES;
  localparam int FBP_NUM_REGIONS = FBP_NUM_UNITS / FBP_UNITS_PER_R;
  localparam int FBP_WORDS       = FBP_FLASH_KB * 1024 / 4;
  localparam int FBP_AW          = $clog2(FBP_WORDS);
  localparam int FBP_UNIT_AW     = $clog2(FBP_UNIT_BYTES / 4);
  localparam int FBP_UW          = $clog2(FBP_NUM_UNITS);
  localparam int FBP_RW          = $clog2(FBP_NUM_REGIONS);
  localparam logic [31:0] FBP_ERASED_WORD = 32'hffff_ffff;

  typedef enum logic [1:0] {
    FBP_OP_PROGRAM = 2'h0,
    FBP_OP_ERASE   = 2'h1
  } fbp_op_t;

  typedef struct packed {
    logic              valid;
    logic [FBP_AW-1:0] addr;
  } fbp_rd_req_t;

  typedef struct packed {
    logic              valid;
    fbp_op_t           op;
    logic [FBP_AW-1:0] addr;
    logic [31:0]       wdata;
  } fbp_wr_req_t;

  typedef struct packed {
    logic        valid;
    logic        denied;
    logic [31:0] rdata;
  } fbp_rd_rsp_t;

  typedef enum logic [1:0] {
    FBP_ST_IDLE  = 2'b00,
    FBP_ST_ERASE = 2'b01
  } fbp_state_t;
endpackage

/* File: fbp_array.sv */
`timescale 1ns/100ps
module fbp_array
  import fbp_pkg::*;
#(
  parameter int WORDS = FBP_WORDS,
  parameter int AW    = FBP_AW
) (
  input  wire logic          mclk,
  input  wire logic [AW-1:0] ra_addr,
  output logic      [31:0]   ra_data,
  input  wire logic [AW-1:0] rb_addr,
  output logic      [31:0]   rb_data,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata
);
  logic [31:0] mem [WORDS];

  // refuse a depth the address cannot reach
  if (WORDS > 2 ** AW) begin : g_bad_depth
    $error("address too narrow for the array depth");
  end

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    ra_data <= mem[ra_addr];
    rb_data <= mem[rb_addr];
  end
endmodule

/* File: fbp_flash_block_protection.sv */
`timescale 1ns/100ps
module fbp_flash_block_protection
  import fbp_pkg::*;
#(
  parameter int NUM_REGIONS = FBP_NUM_REGIONS
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic [NUM_REGIONS-1:0] region_read_only,
  input  wire logic [NUM_REGIONS-1:0] region_exec_only,
  input  wire fbp_rd_req_t            ifetch_req,
  output fbp_rd_rsp_t                 ifetch_rsp,
  input  wire fbp_rd_req_t            dread_req,
  input  wire logic                   dread_is_debug,
  output fbp_rd_rsp_t                 dread_rsp,
  input  wire fbp_wr_req_t            wr_req,
  output logic                        wr_ready,
  output logic                        wr_done,
  output logic                        wr_denied,
  output logic                        violation_q,
  input  wire logic                   violation_clr
);
  // refuse settings the address split cannot serve
  if (NUM_REGIONS != FBP_NUM_REGIONS) begin : g_bad_regions
    $error("region count must match flash size");
  end
  if (FBP_UNITS_PER_R != 2) begin : g_bad_pairing
    $error("regions must pair two erase units");
  end
  if (FBP_UNIT_AW + FBP_UW != FBP_AW) begin : g_bad_split
    $error("unit and word index must fill the address");
  end
  if (FBP_RW + FBP_UNIT_AW + 1 != FBP_AW) begin : g_bad_region_split
    $error("region index must sit above two units");
  end

  fbp_state_t              state_q;
  logic [FBP_UW-1:0]       erase_unit_q;
  logic [FBP_UNIT_AW-1:0]  erase_idx_q;
  logic                    arr_we;
  logic [FBP_AW-1:0]       arr_waddr;
  logic [31:0]             arr_wdata;
  logic [31:0]             if_data;
  logic [31:0]             dr_data;
  logic [FBP_RW-1:0]       dr_reg;
  logic [FBP_RW-1:0]       wr_reg;
  logic                    wr_prot;
  logic                    dr_prot;
  logic                    wr_take;
  logic                    viol_evt;
  logic                    if_valid_q;
  logic                    dr_valid_q;
  logic                    dr_denied_q;
  logic                    wr_is_prog;
  logic                    wr_is_erase;
  logic                    prog_go;
  logic                    erase_go;
  logic                    erase_busy;
  logic                    erase_last;
  logic                    unused_dbg;

  localparam int REG_SLOTS = 2 ** FBP_RW;
  logic [REG_SLOTS-1:0]    region_locked;
  logic [REG_SLOTS-1:0]    region_fetch_only;

  // region index is the address above the two-unit span; fetches ignore it
  assign dr_reg = dread_req.addr[FBP_AW-1 -: FBP_RW];
  assign wr_reg = wr_req.addr[FBP_AW-1 -: FBP_RW];

  // one slot per region; slots past the array have no flash behind them
  for (genvar r = 0; r < REG_SLOTS; r++) begin : g_region
    if (r < NUM_REGIONS) begin : g_real
      assign region_locked[r]     = region_read_only[r] | region_exec_only[r];
      assign region_fetch_only[r] = region_exec_only[r];
    end else begin : g_absent
      assign region_locked[r]     = 1'b1;
      assign region_fetch_only[r] = 1'b0;
    end
  end

  assign wr_prot     = region_locked[wr_reg];
  assign dr_prot     = region_fetch_only[dr_reg];
  assign erase_busy  = (state_q == FBP_ST_ERASE);
  assign erase_last  = erase_busy & (&erase_idx_q);
  assign wr_ready    = ~erase_busy;
  assign wr_take     = wr_req.valid & wr_ready;
  assign wr_is_prog  = (wr_req.op == FBP_OP_PROGRAM);
  assign wr_is_erase = (wr_req.op == FBP_OP_ERASE);
  assign prog_go     = wr_take & ~wr_prot & wr_is_prog;
  assign erase_go    = wr_take & ~wr_prot & wr_is_erase;
  assign viol_evt    = (wr_take & wr_prot) | (dread_req.valid & dr_prot);

  fbp_array i_fbp_array (
    .mclk    (mclk),
    .ra_addr (ifetch_req.addr),
    .ra_data (if_data),
    .rb_addr (dread_req.addr),
    .rb_data (dr_data),
    .we      (arr_we),
    .waddr   (arr_waddr),
    .wdata   (arr_wdata)
  );

  // erase walks one unit word by word; program writes a single word
  always_comb begin
    arr_we    = 1'b0;
    arr_waddr = wr_req.addr;
    arr_wdata = wr_req.wdata;
    if (erase_busy) begin
      arr_we    = 1'b1;
      arr_waddr = {erase_unit_q, erase_idx_q};
      arr_wdata = FBP_ERASED_WORD;
    end else if (prog_go) begin
      arr_we = 1'b1;
    end
  end

  // erase owns the array write port until its last word
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= FBP_ST_IDLE;
    end else begin
      case (state_q)
        FBP_ST_IDLE: begin
          if (erase_go) begin
            state_q <= FBP_ST_ERASE;
          end
        end
        FBP_ST_ERASE: begin
          if (erase_last) begin
            state_q <= FBP_ST_IDLE;
          end
        end
        default: state_q <= FBP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      erase_unit_q <= '0;
    end else if (erase_go) begin
      erase_unit_q <= wr_req.addr[FBP_AW-1 -: FBP_UW];
    end
  end

  // word index inside the unit; wraps to zero after the last word
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      erase_idx_q <= '0;
    end else if (erase_go) begin
      erase_idx_q <= '0;
    end else if (erase_busy) begin
      erase_idx_q <= erase_idx_q + FBP_UNIT_AW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_done <= 1'b0;
    end else begin
      wr_done <= prog_go | erase_last;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_denied <= 1'b0;
    end else begin
      wr_denied <= wr_take & wr_prot;
    end
  end

  // set wins over clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      violation_q <= 1'b0;
    end else if (viol_evt) begin
      violation_q <= 1'b1;
    end else if (violation_clr) begin
      violation_q <= 1'b0;
    end
  end

  // request flags delayed to line up with the array read register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      if_valid_q  <= 1'b0;
      dr_valid_q  <= 1'b0;
      dr_denied_q <= 1'b0;
    end else begin
      if_valid_q  <= ifetch_req.valid;
      dr_valid_q  <= dread_req.valid;
      dr_denied_q <= dread_req.valid & dr_prot;
    end
  end

  // fetches always allowed; denied data reads return zero
  always_comb begin
    ifetch_rsp.valid  = if_valid_q;
    ifetch_rsp.denied = 1'b0;
    ifetch_rsp.rdata  = if_data;
  end

  always_comb begin
    dread_rsp.valid  = dr_valid_q;
    dread_rsp.denied = dr_denied_q;
    dread_rsp.rdata  = dr_denied_q ? 32'h0000_0000 : dr_data;
  end

  // debugger and processor data reads share one policy
  assign unused_dbg = dread_is_debug;
endmodule

/* File: fbp_flash_block_protection_assertions.sv */
`timescale 1ns/100ps
module fbp_chk
  import fbp_pkg::*;
#(parameter int NUM_REGIONS = FBP_NUM_REGIONS) (
  input logic                   mclk,
  input logic                   rst_b,
  input logic [NUM_REGIONS-1:0] region_read_only,
  input logic [NUM_REGIONS-1:0] region_exec_only,
  input fbp_rd_req_t            ifetch_req,
  input fbp_rd_rsp_t            ifetch_rsp,
  input fbp_rd_req_t            dread_req,
  input fbp_rd_rsp_t            dread_rsp,
  input fbp_wr_req_t            wr_req,
  input logic                   wr_ready,
  input logic                   wr_done,
  input logic                   wr_denied,
  input logic                   violation_q,
  input logic                   violation_clr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire xd = region_exec_only[dread_req.addr[14:9]];
  wire tk = wr_req.valid && wr_ready;
  wire pw = region_read_only[wr_req.addr[14:9]] | region_exec_only[wr_req.addr[14:9]];
  property p_frd; ifetch_req.valid |=> ifetch_rsp.valid && !ifetch_rsp.denied; endproperty
  a_frd: assert property (p_frd) else $error("fetch answer wrong");
  property p_xo; dread_req.valid && xd |=> dread_rsp.denied && dread_rsp.rdata == 32'h0 && violation_q; endproperty
  a_xo: assert property (p_xo) else $error("data read not denied");
  property p_ok; dread_req.valid && !xd |=> dread_rsp.valid && !dread_rsp.denied; endproperty
  a_ok: assert property (p_ok) else $error("data read late");
  property p_pg; tk && wr_req.op == FBP_OP_PROGRAM && !pw |=> wr_done && !wr_denied; endproperty
  a_pg: assert property (p_pg) else $error("program not done");
  property p_er; tk && wr_req.op == FBP_OP_ERASE && !pw |=> !wr_ready[*8] ##249 wr_done; endproperty
  a_er: assert property (p_er) else $error("erase timing wrong");
  property p_dn; tk && pw |=> wr_denied && !wr_done && violation_q; endproperty
  a_dn: assert property (p_dn) else $error("write not denied");
  property p_st; violation_q && !violation_clr |=> violation_q; endproperty
  a_st: assert property (p_st) else $error("violation lost");
  property p_rv; $rose(violation_q) |-> $past(tk && pw || dread_req.valid && xd); endproperty
  a_rv: assert property (p_rv) else $error("violation without cause");
  cover property (wr_done);
  cover property (wr_denied);
  cover property (dread_rsp.denied);
endmodule
bind fbp_flash_block_protection fbp_chk #(.NUM_REGIONS(NUM_REGIONS)) i_fbp_chk (.mclk, .rst_b,
  .region_read_only, .region_exec_only, .ifetch_req, .ifetch_rsp, .dread_req, .dread_rsp,
  .wr_req, .wr_ready, .wr_done, .wr_denied, .violation_q, .violation_clr);

/* File: fbp_host.sv */
`timescale 1ns/100ps
module fbp_host
  import fbp_pkg::*;
(
  input  logic        mclk,
  output fbp_rd_req_t ifetch_req,
  output fbp_rd_req_t dread_req,
  output logic        dread_is_debug
);
  initial begin
    ifetch_req = '0;
    dread_req = '0;
    dread_is_debug = 1'b0;
  end
  task automatic rd(input logic [14:0] a, input logic g);
    ifetch_req = '{1'b1, a};
    dread_req = '{1'b1, a};
    dread_is_debug = g;
    @(posedge mclk);
    #1 ifetch_req = '{1'b0, ~a};
    dread_req = '{1'b0, ~a};
    dread_is_debug = ~g;
  endtask
endmodule

/* File: test_flash_block_protection.sv */
`timescale 1ns/100ps
module test_flash_block_protection;
  import fbp_pkg::*;
  logic        mclk = 0, rst_b = 0, violation_clr = 0, dbg, p, v;
  logic        wr_ready, wr_done, wr_denied, violation_q;
  logic [47:0] ro = '0, xo = '0;
  logic [14:0] a;
  logic [31:0] d;
  logic [31:0] mem [int];
  logic [32:0] qf [$], qd [$], qw [$];
  fbp_rd_req_t fq, dq;
  fbp_rd_rsp_t fr, dr;
  fbp_wr_req_t wq = '0;
  int          n_fail = 0, check_count = 0, cyc = 0, seed = 32'h1d6d;
  always #10 mclk = ~mclk;
  fbp_host i_fbp_host (.mclk, .ifetch_req(fq), .dread_req(dq), .dread_is_debug(dbg));
  fbp_flash_block_protection i_fbp_flash_block_protection (.mclk, .rst_b, .region_read_only(ro),
    .region_exec_only(xo), .ifetch_req(fq), .ifetch_rsp(fr), .dread_req(dq), .dread_is_debug(dbg),
    .dread_rsp(dr), .wr_req(wq), .wr_ready, .wr_done, .wr_denied, .violation_q, .violation_clr);
  task chk(input logic [32:0] s, input logic [32:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  task finish_test;
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input fbp_op_t o);
    wq = '{1'b1, o, a, d};
    p = ro[a[14:9]] | xo[a[14:9]];
    v = v | p;
    qw.push_back({31'h0, !p, p});
    if (!p && o == FBP_OP_ERASE) for (int k = 0; k < 256; k++) mem[{a[14:8], 8'(k)}] = '1;
    else if (!p) mem[a] = d;
    @(posedge mclk);
    #1 wq.valid = 1'b0;
    wq.wdata = ~d;
    chk(33'(wr_ready), 33'(!(o == FBP_OP_ERASE && !p)));
    repeat (258) @(posedge mclk);
    #1;
    chk(33'(wr_ready), 33'h1);
  endtask
  task rd;
    qf.push_back({1'b0, mem[a]});
    qd.push_back(xo[a[14:9]] ? {1'b1, 32'h0} : {1'b0, mem[a]});
    v = v | xo[a[14:9]];
    i_fbp_host.rd(a, 1'($random(seed)));
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 9000) begin
      n_fail++;
      finish_test;
    end else begin
      if (fr.valid === 1'b1) chk({fr.denied, fr.rdata}, qf.pop_front());
      if (dr.valid === 1'b1) chk({dr.denied, dr.rdata}, qd.pop_front());
      if ((wr_done | wr_denied) === 1'b1) chk(33'({wr_done, wr_denied}), qw.pop_front());
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    #1 rst_b = 1;
    for (int i = 0; i < 16; i++) begin
      if (i == 8) begin
        ro = 48'({$random(seed), $random(seed)});
        xo = 48'({$random(seed), $random(seed)});
      end
      a = {7'((i % 8) * 13), 8'h00};
      d = $random(seed);
      v = 1'b0;
      wr(FBP_OP_ERASE);
      rd;
      a[7:0] = {7'($random(seed) | 1), i[3]};
      wr(FBP_OP_PROGRAM);
      rd;
      chk(33'(violation_q), 33'(v));
      violation_clr = 1;
      @(posedge mclk);
      #1 violation_clr = 0;
      chk(33'(violation_q), 33'h0);
    end
    repeat (2) @(posedge mclk);
    chk(33'(qf.size() + qd.size() + qw.size()), 33'h0);
    finish_test;
  end
endmodule
